/* bench/dmasg_chan_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module dmasg_chan_tb_top
	import dmasg_pkg::*;
;
	logic           mclk, sys_rst, start, busy_q, tc_irq_q, err_irq_q, slow;
	logic [31:0]    err_addr;
	dmasg_item_t    first_item;
	dmasg_ahb_rsp_t ahb_rsp;
	dmasg_ahb_req_t ahb_q;
	int             mismatches, comparisons, tc_n, err_n;
	logic [31:0]    nq [$];

	dmasg_chan #(.DEPTH(32)) u_dut (.mclk(mclk), .sys_rst(sys_rst), .start(start),
		.first_item(first_item), .ahb_rsp(ahb_rsp), .ahb_q(ahb_q), .busy_q(busy_q),
		.tc_irq_q(tc_irq_q), .err_irq_q(err_irq_q));
	dmasg_mem u_mem (.mclk(mclk), .sys_rst(sys_rst), .ahb_q(ahb_q), .slow(slow),
		.err_addr(err_addr), .ahb_rsp(ahb_rsp));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (ahb_q.htrans == 2'h2 && ahb_rsp.hready === 1'b1)
			nq.push_back(ahb_q.haddr);
		if (tc_irq_q === 1'b1)
			tc_n++;
		if (err_irq_q === 1'b1)
			err_n++;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] pat(input int i);
		return 32'hA5A5_0000 + 32'(i);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic run(input logic [31:0] s, d, n, c);
		int k;
		nq.delete();
		tc_n = 0;
		err_n = 0;
		k = 0;
		first_item = '{s, d, n, c};
		start = 1'b1;
		@(negedge mclk);
		start = 1'b0;
		@(negedge mclk);
		chk(busy_q, 1'b1);
		while (busy_q === 1'b1 && k < 2000) begin
			@(negedge mclk);
			k++;
		end
		repeat (3) @(negedge mclk);
		chk(busy_q, 1'b0);
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_split();
		run(32'h0C00_0024, 32'h0C00_0224, 32'h0, 32'h8C08_3010);
		chk(nq.size(), 4);
		chk(nq[1], 32'h0C00_0040);
		chk(nq[3], 32'h0C00_0240);
		chk(tc_n, 1);
		for (int i = 0; i < 16; i++)
			chk(u_mem.mem[137 + i], pat(9 + i));
	endtask
	task automatic t_chain();
		slow = 1'b1;
		run(32'h300, 32'h400, 32'h500, 32'h8C08_1004);
		chk(nq[2], 32'h500);
		chk(tc_n, 2);
		for (int i = 0; i < 8; i++)
			chk(u_mem.mem[256 + i], pat(192 + i));
		slow = 1'b0;
	endtask
	task automatic t_fixed();
		run(32'h300, 32'h600, 32'h0, 32'h0408_1008);
		chk(nq.size(), 4);
		chk(nq[2], 32'h310);
		chk(nq[3], 32'h600);
		chk(u_mem.mem[384], pat(199));
		chk(u_mem.mem[385], pat(385));
		chk(tc_n, 0);
	endtask
	task automatic t_err();
		err_addr = 32'h308;
		run(32'h300, 32'h700, 32'h0, 32'h8C08_1004);
		chk(err_n, 1);
		chk(tc_n, 0);
		chk(u_mem.mem[448], pat(448));
		err_addr = 32'hFFFF_FFFC;
		run(32'h300, 32'h700, 32'h0, 32'h8C08_1004);
		chk(u_mem.mem[448], pat(192));
		chk(tc_n, 1);
	endtask

	initial begin
		sys_rst = 1'b1;
		start = 1'b0;
		first_item = '0;
		slow = 1'b0;
		err_addr = 32'hFFFF_FFFC;
		for (int i = 0; i < 1024; i++)
			u_mem.mem[i] = pat(i);
		u_mem.mem[320] = 32'h310;
		u_mem.mem[321] = 32'h410;
		u_mem.mem[322] = 32'h0;
		u_mem.mem[323] = 32'h8C08_1004;
		repeat (10) @(negedge mclk);
		sys_rst = 1'b0;
		t_split();
		t_chain();
		t_fixed();
		t_err();
		end_sim();
	end
	initial begin
		#1000000;
		mismatches++;
		end_sim();
	end
endmodule

bind dmasg_chan dmasg_chk #(.DEPTH(DEPTH)) u_chk (.mclk(mclk), .sys_rst(sys_rst),
	.start(start), .first_item(first_item), .ahb_rsp(ahb_rsp), .ahb_q(ahb_q),
	.busy_q(busy_q), .tc_irq_q(tc_irq_q), .err_irq_q(err_irq_q));

`default_nettype wire

/* bench/dmasg_chk_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dmasg_regs.svh"

module dmasg_chk
	import dmasg_pkg::*;
#(
	parameter int DEPTH = 32
) (
	input wire logic           mclk,
	input wire logic           sys_rst,
	input wire logic           start,
	input wire dmasg_item_t    first_item,
	input wire dmasg_ahb_rsp_t ahb_rsp,
	input wire dmasg_ahb_req_t ahb_q,
	input wire logic           busy_q,
	input wire logic           tc_irq_q,
	input wire logic           err_irq_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// boundary mask of the started item
	// ----------------------------------------
	logic [31:0] ctl_q;
	logic [5:0]  beats;
	logic [31:0] mask;
	assign beats = (ctl_q[14:12] > 3'h3) ? 6'h20 :
		(ctl_q[14:12] == 3'h0) ? 6'h01 : 6'h02 << ctl_q[14:12];
	assign mask = ({26'h0, beats} << ctl_q[19:18]) - 32'h1;
	always_ff @(posedge mclk) begin
		if (sys_rst)
			ctl_q <= '0;
		else if (start && !busy_q)
			ctl_q <= first_item.channel_control;
	end

	a_start_busy: assert property (start && !busy_q |=> busy_q)
		else $error("busy not raised after start");
	a_first_beat: assert property (start && !busy_q && first_item.channel_control[11:0] != 12'h0
		|-> ##[1:4] ahb_q.htrans == `DMASG_TRANS_NSEQ)
		else $error("no first transfer after start");
	a_req_hold: assert property (ahb_q.htrans[1] && !ahb_rsp.hready && !ahb_rsp.hresp
		|=> $stable(ahb_q.haddr) && $stable(ahb_q.htrans))
		else $error("request changed while stalled");
	a_no_wrap: assert property (ahb_q.htrans == `DMASG_TRANS_SEQ |-> ahb_q.haddr == $past(ahb_q.haddr)
		|| ahb_q.haddr == $past(ahb_q.haddr) + (32'h1 << ahb_q.hsize))
		else $error("address neither held nor stepped");
	a_split_bound: assert property (ahb_q.htrans == `DMASG_TRANS_SEQ
		&& ahb_q.haddr != $past(ahb_q.haddr) |-> (ahb_q.haddr & mask) != 32'h0)
		else $error("burst runs across boundary");
	a_tc_pulse: assert property (tc_irq_q |=> !tc_irq_q)
		else $error("terminal pulse too long");
	a_err_cause: assert property (err_irq_q |-> $past(ahb_rsp.hresp))
		else $error("error pulse without bus error");
	a_err_stop: assert property (err_irq_q
		|-> ##[0:2] (!busy_q && ahb_q.htrans == `DMASG_TRANS_IDLE))
		else $error("stream not stopped on error");
	a_idle_quiet: assert property (!busy_q && !$past(busy_q)
		|-> ahb_q.htrans == `DMASG_TRANS_IDLE)
		else $error("bus active while idle");
	a_burst_kind: assert property (ahb_q.htrans[1] |-> ahb_q.hburst == `DMASG_BURST_INCR
		&& (ahb_q.hsize == ctl_q[20:18] || ahb_q.hsize == `DMASG_SIZE_WORD))
		else $error("burst kind or size wrong");
	c_err: cover property (err_irq_q);
	c_tc: cover property (tc_irq_q);
	c_stall: cover property (ahb_q.htrans == `DMASG_TRANS_SEQ && !ahb_rsp.hready);
endmodule

`default_nettype wire

/* bench/dmasg_mem.sv */
`timescale 1ns/1ns
`default_nettype none

module dmasg_mem
	import dmasg_pkg::*;
(
	input  wire logic           mclk,
	input  wire logic           sys_rst,
	input  wire dmasg_ahb_req_t ahb_q,
	input  wire logic           slow,
	input  wire logic [31:0]    err_addr,
	output dmasg_ahb_rsp_t      ahb_rsp
);
	logic [31:0] mem [0:1023];
	logic [31:0] dp_a_q;
	logic        dp_q, wr_q, er_q, er2_q, wt_q, tog_q;
	logic        rdy;
	logic [31:0] rd;
	// two-cycle error response, wait every other cycle when slow
	assign rdy = !(slow && wt_q) && !(er_q && !er2_q);
	assign rd = (dp_q && !wr_q) ? mem[dp_a_q[11:2]] : {32{tog_q}};
	assign ahb_rsp = '{rd, rdy, dp_q && er_q};
	always @(posedge mclk) begin
		if (sys_rst) begin
			{dp_q, wr_q, er_q, er2_q, wt_q, tog_q} <= '0;
			dp_a_q <= '0;
		end else begin
			tog_q <= !tog_q;
			wt_q <= slow && !wt_q;
			if (rdy) begin
				if (dp_q && wr_q && !er_q)
					mem[dp_a_q[11:2]] <= ahb_q.hwdata;
				dp_q <= ahb_q.htrans[1];
				wr_q <= ahb_q.hwrite;
				er_q <= ahb_q.htrans[1] && ahb_q.haddr == err_addr;
				dp_a_q <= ahb_q.haddr;
				er2_q <= 1'b0;
			end else if (er_q) begin
				er2_q <= 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

/* common/dmasg_pkg.sv */
package dmasg_pkg;

	typedef enum logic [2:0] {
		DMASG_IDLE  = 3'b000,
		DMASG_NEXT  = 3'b001,
		DMASG_FETCH = 3'b010,
		DMASG_READ  = 3'b011,
		DMASG_WRITE = 3'b100
	} dmasg_state_t;

	typedef struct packed {
		logic [31:0] source_address;
		logic [31:0] destination_address;
		logic [31:0] next_item_pointer;
		logic [31:0] channel_control;
	} dmasg_item_t;

	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [2:0]  hburst;
		logic [31:0] hwdata;
	} dmasg_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hready;
		logic        hresp;
	} dmasg_ahb_rsp_t;

endpackage

/* common/dmasg_regs.svh */
`ifndef DMASG_REGS_SVH
`define DMASG_REGS_SVH

// ----------------------------------------------------------------------
// channel control word layout
// ----------------------------------------------------------------------
`define DMASG_CNT_HI      11
`define DMASG_CNT_LO      0
`define DMASG_BURST_HI    14
`define DMASG_BURST_LO    12
`define DMASG_WIDTH_HI    20
`define DMASG_WIDTH_LO    18
`define DMASG_SRC_INC     26
`define DMASG_DST_INC     27
`define DMASG_TC_IE       31

// ----------------------------------------------------------------------
// burst size codes and beat counts
// ----------------------------------------------------------------------
`define DMASG_BCODE_1     3'h0
`define DMASG_BCODE_4     3'h1
`define DMASG_BCODE_8     3'h2
`define DMASG_BCODE_16    3'h3
`define DMASG_BEATS_1     12'h001
`define DMASG_BEATS_4     12'h004
`define DMASG_BEATS_8     12'h008
`define DMASG_BEATS_16    12'h010
`define DMASG_BEATS_32    12'h020

// ----------------------------------------------------------------------
// bus encodings and item layout
// ----------------------------------------------------------------------
`define DMASG_TRANS_IDLE  2'h0
`define DMASG_TRANS_NSEQ  2'h2
`define DMASG_TRANS_SEQ   2'h3
`define DMASG_BURST_INCR  3'h1
`define DMASG_SIZE_WORD   3'h2
`define DMASG_ITEM_WORDS  12'h004
`define DMASG_WORD_STEP   32'h0000_0004
`define DMASG_WORD_SRC    2'h0
`define DMASG_WORD_DST    2'h1
`define DMASG_WORD_NEXT   2'h2
`define DMASG_WORD_CTRL   2'h3

`endif

/* hw/dmasg_chan.sv */
// Behaviour
// - each side increments or holds address, no wrap
// - boundary equals burst beats times transfer width
// - burst crossing boundary splits into separate transactions
// - items chain blocks, then fetch next or stop
// - item is four words, source then destination
// - one block moves in as many bursts needed
// - zero count reloads from nonzero pointer, zero stops
// - terminal count pulse per block, error stops stream
`timescale 1ns/1ns
`default_nettype none
`include "dmasg_regs.svh"

module dmasg_chan
	import dmasg_pkg::*;
#(
	parameter int DEPTH = 32
) (
	input  wire logic           mclk,
	input  wire logic           sys_rst,
	input  wire logic           start,
	input  wire dmasg_item_t    first_item,
	input  wire dmasg_ahb_rsp_t ahb_rsp,
	output dmasg_ahb_req_t      ahb_q,
	output logic                busy_q,
	output logic                tc_irq_q,
	output logic                err_irq_q
);
	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	dmasg_state_t state_q;
	logic [31:0]  src_q;
	logic [31:0]  dst_q;
	logic [31:0]  next_q;
	logic [31:0]  ctrl_q;
	logic [11:0]  cnt_q;
	logic [11:0]  pass_q;
	logic [11:0]  left_q;
	logic [11:0]  done_q;
	logic         dph_q;
	logic [1:0]   widx_q;

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	wire [2:0]  wsz   = ctrl_q[`DMASG_WIDTH_HI:`DMASG_WIDTH_LO];
	wire [2:0]  bcode = ctrl_q[`DMASG_BURST_HI:`DMASG_BURST_LO];
	wire [31:0] step  = 32'h0000_0001 << wsz;
	wire [11:0] beats = (bcode == `DMASG_BCODE_1)  ? `DMASG_BEATS_1 :
	                    (bcode == `DMASG_BCODE_4)  ? `DMASG_BEATS_4 :
	                    (bcode == `DMASG_BCODE_8)  ? `DMASG_BEATS_8 :
	                    (bcode == `DMASG_BCODE_16) ? `DMASG_BEATS_16 : `DMASG_BEATS_32;
	// boundary span in bytes, minus one
	wire [31:0] bnd_mask = ({20'h0, beats} << wsz) - 32'h0000_0001;
	wire [11:0] depth_n  = 12'(DEPTH);
	wire [11:0] min_bc   = (beats < cnt_q) ? beats : cnt_q;
	// one pass never exceeds the buffer, so a read pass cannot overflow it
	wire [11:0] pass_n   = (min_bc < depth_n) ? min_bc : depth_n;

	wire        fetching = (state_q == DMASG_FETCH);
	wire        cur_inc  = fetching ? 1'b1 :
	                       (state_q == DMASG_READ) ? ctrl_q[`DMASG_SRC_INC] : ctrl_q[`DMASG_DST_INC];
	wire [31:0] cur_step = fetching ? `DMASG_WORD_STEP : step;
	wire [31:0] addr_nxt = ahb_q.haddr + (cur_inc ? cur_step : 32'h0);
	// a new transaction opens on each boundary, so the first part ends there
	wire        at_bnd   = !fetching && cur_inc && ((addr_nxt & bnd_mask) == 32'h0);

	wire        beat_ok  = ahb_q.htrans[1] && ahb_rsp.hready;
	wire        dbeat    = dph_q && ahb_rsp.hready;
	wire        bus_err  = dph_q && ahb_rsp.hresp;
	wire        last_d   = dbeat && (done_q == 12'h001);

	wire        f_in_ready;
	wire        f_out_valid;
	wire [31:0] f_out_data;
	wire        f_push   = (state_q == DMASG_READ) && dbeat && !ahb_rsp.hresp;
	wire        f_pop    = (state_q == DMASG_WRITE) && beat_ok;
	// partial pass data dropped after a bus error
	wire        f_clr    = sys_rst || err_irq_q;

	// ------------------------------------------------------------------
	// data buffer between read and write passes
	// ------------------------------------------------------------------
	dmasg_fifo #(
		.W (32),
		.D (DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.sys_rst   (f_clr),
		.in_valid  (f_push),
		.in_data   (ahb_rsp.hrdata),
		.in_ready  (f_in_ready),
		.out_valid (f_out_valid),
		.out_data  (f_out_data),
		.out_ready (f_pop)
	);

	// ------------------------------------------------------------------
	// data phase tracking
	// ------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dph_q <= 1'b0;
		end else begin
			if (ahb_rsp.hready || bus_err) dph_q <= beat_ok && !bus_err;
		end
	end

	// ------------------------------------------------------------------
	// sequencer and address phase
	// ------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q      <= DMASG_IDLE;
			src_q        <= 32'h0;
			dst_q        <= 32'h0;
			next_q       <= 32'h0;
			ctrl_q       <= 32'h0;
			cnt_q        <= 12'h0;
			pass_q       <= 12'h0;
			left_q       <= 12'h0;
			done_q       <= 12'h0;
			widx_q       <= 2'h0;
			ahb_q.haddr  <= 32'h0;
			ahb_q.htrans <= `DMASG_TRANS_IDLE;
			ahb_q.hwrite <= 1'b0;
			ahb_q.hsize  <= `DMASG_SIZE_WORD;
			ahb_q.hburst <= `DMASG_BURST_INCR;
			ahb_q.hwdata <= 32'h0;
			busy_q       <= 1'b0;
			tc_irq_q     <= 1'b0;
			err_irq_q    <= 1'b0;
		end else begin
			tc_irq_q  <= 1'b0;
			err_irq_q <= 1'b0;
			if (beat_ok) begin
				ahb_q.haddr <= addr_nxt;
				left_q      <= left_q - 12'h001;
				if (left_q == 12'h001) ahb_q.htrans <= `DMASG_TRANS_IDLE;
				else if (at_bnd) ahb_q.htrans <= `DMASG_TRANS_NSEQ;
				else ahb_q.htrans <= `DMASG_TRANS_SEQ;
			end
			if (dbeat) done_q <= done_q - 12'h001;
			if (f_pop && f_out_valid) ahb_q.hwdata <= f_out_data;
			case (state_q)
				DMASG_IDLE: begin
					if (start) begin
						src_q   <= first_item.source_address;
						dst_q   <= first_item.destination_address;
						next_q  <= first_item.next_item_pointer;
						ctrl_q  <= first_item.channel_control;
						cnt_q   <= first_item.channel_control[`DMASG_CNT_HI:`DMASG_CNT_LO];
						busy_q  <= 1'b1;
						state_q <= DMASG_NEXT;
					end
				end
				DMASG_NEXT: begin
					if (cnt_q == 12'h0) begin
						tc_irq_q <= ctrl_q[`DMASG_TC_IE];
						if (next_q != 32'h0) begin
							ahb_q.haddr  <= next_q;
							ahb_q.htrans <= `DMASG_TRANS_NSEQ;
							ahb_q.hwrite <= 1'b0;
							ahb_q.hsize  <= `DMASG_SIZE_WORD;
							left_q       <= `DMASG_ITEM_WORDS;
							done_q       <= `DMASG_ITEM_WORDS;
							widx_q       <= `DMASG_WORD_SRC;
							state_q      <= DMASG_FETCH;
						end else begin
							busy_q  <= 1'b0;
							state_q <= DMASG_IDLE;
						end
					end else if (f_in_ready && !f_out_valid) begin
						ahb_q.haddr  <= src_q;
						ahb_q.htrans <= `DMASG_TRANS_NSEQ;
						ahb_q.hwrite <= 1'b0;
						ahb_q.hsize  <= wsz;
						left_q       <= pass_n;
						done_q       <= pass_n;
						pass_q       <= pass_n;
						state_q      <= DMASG_READ;
					end
				end
				DMASG_FETCH: begin
					if (dbeat && !ahb_rsp.hresp) begin
						widx_q <= widx_q + 2'h1;
						case (widx_q)
							`DMASG_WORD_SRC:  src_q  <= ahb_rsp.hrdata;
							`DMASG_WORD_DST:  dst_q  <= ahb_rsp.hrdata;
							`DMASG_WORD_NEXT: next_q <= ahb_rsp.hrdata;
							default: begin
								ctrl_q <= ahb_rsp.hrdata;
								cnt_q  <= ahb_rsp.hrdata[`DMASG_CNT_HI:`DMASG_CNT_LO];
							end
						endcase
						if (last_d) state_q <= DMASG_NEXT;
					end
				end
				DMASG_READ: begin
					if (beat_ok) src_q <= addr_nxt;
					if (last_d && !ahb_rsp.hresp) begin
						ahb_q.haddr  <= dst_q;
						ahb_q.htrans <= `DMASG_TRANS_NSEQ;
						ahb_q.hwrite <= 1'b1;
						left_q       <= pass_q;
						done_q       <= pass_q;
						state_q      <= DMASG_WRITE;
					end
				end
				DMASG_WRITE: begin
					if (beat_ok) dst_q <= addr_nxt;
					if (last_d && !ahb_rsp.hresp) begin
						ahb_q.hwrite <= 1'b0;
						cnt_q        <= cnt_q - pass_q;
						state_q      <= DMASG_NEXT;
					end
				end
				default: begin
					state_q <= DMASG_IDLE;
				end
			endcase
			if (bus_err) begin
				ahb_q.htrans <= `DMASG_TRANS_IDLE;
				ahb_q.hwrite <= 1'b0;
				err_irq_q    <= 1'b1;
				busy_q       <= 1'b0;
				state_q      <= DMASG_IDLE;
			end
		end
	end
endmodule

`default_nettype wire

/* hw/dmasg_fifo.sv */
`timescale 1ns/1ns
`default_nettype none

module dmasg_fifo #(
	parameter int W = 32,
	parameter int D = 32
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D + 1);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [CW-1:0] cnt_q;
	logic          ov_q;
	logic [W-1:0]  od_q;

	wire            out_free = !ov_q || out_ready;
	wire            in_fire  = in_valid && in_ready;
	wire            mem_pop  = (cnt_q != '0) && out_free;
	wire            bypass   = in_fire && (cnt_q == '0) && out_free;
	wire            mem_push = in_fire && !bypass;
	wire [CW:0]     total    = {1'b0, cnt_q} + {{CW{1'b0}}, ov_q};

	assign in_ready  = total < (CW + 1)'(D);
	assign out_valid = ov_q;
	assign out_data  = od_q;

	always_ff @(posedge mclk) begin
		if (mem_push) begin
			mem[wp_q] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
			ov_q  <= 1'b0;
			od_q  <= '0;
		end else begin
			if (mem_push) wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
			if (mem_pop) rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + CW'(mem_push) - CW'(mem_pop);
			if (mem_pop) begin
				od_q <= mem[rp_q];
				ov_q <= 1'b1;
			end else if (bypass) begin
				od_q <= in_data;
				ov_q <= 1'b1;
			end else if (out_ready) begin
				ov_q <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire
